// *** core/cic_i2c_slave.sv ***
`timescale 1ns/1ps
// two-wire control slave: protocol engine on the link sampling clock,
// register store on the reference clock
module cic_i2c_slave (
    input  wire logic   ref_clk_i,
    input  wire logic   rst_i,
    input  wire logic   link_clk_i,
    input  wire logic   control_clock_pin_i,
    input  wire logic   control_data_pin_i,
    output logic        control_data_pin_o,
    output logic        control_data_oe_n_o,
    input  wire logic   control_mode_pin_i,
    output logic        quick_mute_o,
    output logic        reg_wr_o,
    output logic [7:0]  reg_addr_o,
    output logic [15:0] reg_data_o
);
    cic_xfer_if xfer ();

    cic_pkg::cic_link_state_type r;
    cic_pkg::cic_link_state_type n;
    logic                        link_rst;
    logic                        scl_new;
    logic                        sda_new;
    logic                        ack_new;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        start_cond;
    logic                        stop_cond;
    logic                        chan_idle;
    logic                        byte_done;
    logic                        bit_slot;

    // take a new level once second and third stage agree
    function automatic logic cic_filt(input logic [2:0] sh,
                                      input logic       prev);
        cic_filt = (sh[1] == sh[2]) ? sh[2] : prev;
    endfunction

    // address byte: seven address bits then the R/W bit
    function automatic logic cic_addr_hit(input logic [7:0] b);
        cic_addr_hit = (b[7:1] == cic_pkg::CIC_DEV_ADDR);
    endfunction

    // shift one received bit in behind the earlier ones
    function automatic logic [7:0] cic_shift_in(input logic [7:0] b,
                                                input logic       d);
        cic_shift_in = {b[6:0], d};
    endfunction

    // reset arrives from the reference domain through three stages
    assign link_rst = r.rst_sh[2];

    // filtered pin and answer levels
    assign scl_new = cic_filt(r.scl_sh, r.scl_f);
    assign sda_new = cic_filt(r.sda_sh, r.sda_f);
    assign ack_new = cic_filt(r.ack_sh, r.ack_f);

    // clock edges and bus conditions
    assign scl_rise   = !r.scl_f && scl_new;
    assign scl_fall   = r.scl_f && !scl_new;
    assign start_cond = r.scl_f && scl_new && r.sda_f && !sda_new;
    assign stop_cond  = r.scl_f && scl_new && !r.sda_f && sda_new;

    // handshake free once the last request was answered
    assign chan_idle = (r.req_tgl == r.ack_f);

    // eight bits counted and the clock has fallen after the last
    assign byte_done = scl_fall && (r.bitcnt == cic_pkg::CIC_BITS_PER_BYTE);
    assign bit_slot  = scl_rise && (r.bitcnt != cic_pkg::CIC_BITS_PER_BYTE);

    // next state of the whole link side
    always_comb begin
        n        = r;
        n.rst_sh = {r.rst_sh[1:0], rst_i};
        n.scl_sh = {r.scl_sh[1:0], control_clock_pin_i};
        n.sda_sh = {r.sda_sh[1:0], control_data_pin_i};
        n.ack_sh = {r.ack_sh[1:0], xfer.ack_tgl};
        n.scl_f  = scl_new;
        n.sda_f  = sda_new;
        n.ack_f  = ack_new;

        // read answer held stable by the store until the next request
        if (ack_new != r.ack_f && !r.req_we) begin
            n.rd_word = xfer.rdata;
        end

        // a pending write goes before a pending prefetch
        if (chan_idle) begin
            if (r.pend_wr) begin
                n.req_tgl   = ~r.req_tgl;
                n.req_we    = 1'b1;
                n.req_ptr   = r.wr_ptr;
                n.req_wdata = r.wr_data;
                n.pend_wr   = 1'b0;
            end else if (r.pend_rd) begin
                n.req_tgl = ~r.req_tgl;
                n.req_we  = 1'b0;
                n.req_ptr = r.ptr;
                n.pend_rd = 1'b0;
            end
        end

        // bus conditions override any byte in progress
        if (start_cond) begin
            n.state  = cic_pkg::CIC_ST_ADDR;
            n.bitcnt = cic_pkg::CIC_BIT_RST;
            n.oe_n   = 1'b1;
        end else if (stop_cond) begin
            n.state  = cic_pkg::CIC_ST_IDLE;
            n.bitcnt = cic_pkg::CIC_BIT_RST;
            n.oe_n   = 1'b1;
        end else begin
            case (r.state)
                cic_pkg::CIC_ST_ADDR: begin
                    if (bit_slot) begin
                        n.shreg  = cic_shift_in(r.shreg, sda_new);
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (byte_done) begin
                        n.bitcnt = cic_pkg::CIC_BIT_RST;
                        if (cic_addr_hit(r.shreg)) begin
                            n.rw    = r.shreg[0];
                            n.kind  = cic_pkg::CIC_ACK_ADDR;
                            n.state = cic_pkg::CIC_ST_SACK;
                            n.oe_n  = 1'b0;
                        end else begin
                            n.state = cic_pkg::CIC_ST_WAIT;
                        end
                    end
                end

                cic_pkg::CIC_ST_PTR: begin
                    if (bit_slot) begin
                        n.shreg  = cic_shift_in(r.shreg, sda_new);
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (byte_done) begin
                        n.bitcnt  = cic_pkg::CIC_BIT_RST;
                        n.ptr     = r.shreg;
                        n.pend_rd = 1'b1;
                        n.kind    = cic_pkg::CIC_ACK_PTR;
                        n.state   = cic_pkg::CIC_ST_SACK;
                        n.oe_n    = 1'b0;
                    end
                end

                cic_pkg::CIC_ST_WDATA: begin
                    if (bit_slot) begin
                        n.shreg  = cic_shift_in(r.shreg, sda_new);
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (byte_done) begin
                        n.bitcnt = cic_pkg::CIC_BIT_RST;
                        if (!r.lo_next) begin
                            n.hi_byte = r.shreg;
                            n.lo_next = 1'b1;
                        end else begin
                            // whole group in: write it, step the pointer
                            n.wr_data = {r.hi_byte, r.shreg};
                            n.wr_ptr  = r.ptr;
                            n.pend_wr = 1'b1;
                            n.ptr     = r.ptr + cic_pkg::CIC_PTR_STEP;
                            n.pend_rd = 1'b1;
                            n.lo_next = 1'b0;
                        end
                        n.kind  = cic_pkg::CIC_ACK_DATA;
                        n.state = cic_pkg::CIC_ST_SACK;
                        n.oe_n  = 1'b0;
                    end
                end

                // slave holds SDA low for the whole ninth clock
                cic_pkg::CIC_ST_SACK: begin
                    // release only once the ninth clock has fallen
                    if (scl_fall) begin
                        n.oe_n   = 1'b1;
                        n.bitcnt = cic_pkg::CIC_BIT_RST;
                        case (r.kind)
                            cic_pkg::CIC_ACK_ADDR: begin
                                if (r.rw) begin
                                    n.state   = cic_pkg::CIC_ST_RDATA;
                                    n.shreg   = r.rd_word[15:8];
                                    n.oe_n    = r.rd_word[15];
                                    n.lo_next = 1'b1;
                                end else begin
                                    n.state = cic_pkg::CIC_ST_PTR;
                                end
                            end
                            cic_pkg::CIC_ACK_PTR: begin
                                n.state   = cic_pkg::CIC_ST_WDATA;
                                n.lo_next = 1'b0;
                            end
                            default: begin
                                n.state = cic_pkg::CIC_ST_WDATA;
                            end
                        endcase
                    end
                end

                // read byte out, bit changes only while SCL is low
                cic_pkg::CIC_ST_RDATA: begin
                    if (bit_slot) begin
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (byte_done) begin
                        n.bitcnt = cic_pkg::CIC_BIT_RST;
                        n.oe_n   = 1'b1;
                        n.mack   = 1'b0;
                        n.state  = cic_pkg::CIC_ST_MACK;
                    end else if (scl_fall) begin
                        n.shreg = {r.shreg[6:0], 1'b0};
                        n.oe_n  = r.shreg[6];
                    end
                end

                // master answers; a missing ack ends the read
                cic_pkg::CIC_ST_MACK: begin
                    if (scl_rise) begin
                        n.mack = !sda_new;
                    end else if (scl_fall) begin
                        n.bitcnt = cic_pkg::CIC_BIT_RST;
                        if (r.mack) begin
                            n.state = cic_pkg::CIC_ST_RDATA;
                            if (r.lo_next) begin
                                n.shreg   = r.rd_word[7:0];
                                n.oe_n    = r.rd_word[7];
                                n.lo_next = 1'b0;
                                n.ptr     = r.ptr + cic_pkg::CIC_PTR_STEP;
                                n.pend_rd = 1'b1;
                            end else begin
                                n.shreg   = r.rd_word[15:8];
                                n.oe_n    = r.rd_word[15];
                                n.lo_next = 1'b1;
                            end
                        end else begin
                            n.state = cic_pkg::CIC_ST_WAIT;
                            n.oe_n  = 1'b1;
                        end
                    end
                end

                // idle or not addressed: SDA stays released
                default: begin
                    n.oe_n = 1'b1;
                end
            endcase
        end

        // keep the reset synchroniser running through reset
        if (link_rst) begin
            n        = cic_pkg::CIC_LINK_RST;
            n.rst_sh = {r.rst_sh[1:0], rst_i};
            n.scl_sh = {r.scl_sh[1:0], control_clock_pin_i};
            n.sda_sh = {r.sda_sh[1:0], control_data_pin_i};
            n.ack_sh = {r.ack_sh[1:0], xfer.ack_tgl};
            n.ack_f  = ack_new;
            n.req_tgl = ack_new;
        end
    end

    // link domain state register
    always_ff @(posedge link_clk_i) begin
        r <= n;
    end

    // requests into the store; fields held until the answer returns
    assign xfer.req_tgl   = r.req_tgl;
    assign xfer.req_we    = r.req_we;
    assign xfer.req_ptr   = r.req_ptr;
    assign xfer.req_wdata = r.req_wdata;

    // SDA only ever pulled low, SCL never driven
    assign control_data_pin_o  = r.sda_out;
    assign control_data_oe_n_o = r.oe_n;

    // register array, quick mute and write strobe on the ref clock
    cic_reg_store u_store (
        .ref_clk_i          (ref_clk_i),
        .rst_i              (rst_i),
        .control_mode_pin_i (control_mode_pin_i),
        .xfer               (xfer.store),
        .quick_mute_o       (quick_mute_o),
        .reg_wr_o           (reg_wr_o),
        .reg_addr_o         (reg_addr_o),
        .reg_data_o         (reg_data_o)
    );
endmodule

// *** include/cic_pkg.sv ***
package cic_pkg;

    // own seven-bit bus address
    localparam logic [6:0]  CIC_DEV_ADDR      = 7'h18;
    localparam logic [3:0]  CIC_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0]  CIC_BIT_RST       = 4'h0;
    localparam logic [7:0]  CIC_PTR_RST       = 8'h00;
    localparam logic [7:0]  CIC_PTR_STEP      = 8'h01;
    localparam logic [15:0] CIC_WORD_RST      = 16'h0000;
    localparam int          CIC_REG_COUNT     = 256;
    // fastest bus clock the master may use, and its period in ref cycles
    localparam int          CIC_SCL_MAX_KHZ   = 400;
    localparam int          CIC_REF_MHZ       = 125;
    localparam int          CIC_SCL_MIN_CYC   =
        (CIC_REF_MHZ * 1000 + CIC_SCL_MAX_KHZ - 1) / CIC_SCL_MAX_KHZ;

    typedef enum logic [3:0] {
        CIC_ST_IDLE  = 4'h0,
        CIC_ST_ADDR  = 4'h1,
        CIC_ST_SACK  = 4'h3,
        CIC_ST_PTR   = 4'h2,
        CIC_ST_WDATA = 4'h6,
        CIC_ST_RDATA = 4'h7,
        CIC_ST_MACK  = 4'h5,
        CIC_ST_WAIT  = 4'h4
    } cic_state_type;

    typedef enum logic [1:0] {
        CIC_ACK_ADDR = 2'h0,
        CIC_ACK_PTR  = 2'h1,
        CIC_ACK_DATA = 2'h2
    } cic_ack_kind_type;

    typedef struct packed {
        logic [2:0]       rst_sh;
        logic [2:0]       scl_sh;
        logic [2:0]       sda_sh;
        logic [2:0]       ack_sh;
        logic             scl_f;
        logic             sda_f;
        logic             ack_f;
        cic_state_type    state;
        cic_ack_kind_type kind;
        logic [3:0]       bitcnt;
        logic [7:0]       shreg;
        logic             rw;
        logic             lo_next;
        logic             mack;
        logic [7:0]       ptr;
        logic [7:0]       hi_byte;
        logic [15:0]      rd_word;
        logic             pend_wr;
        logic             pend_rd;
        logic [7:0]       wr_ptr;
        logic [15:0]      wr_data;
        logic             req_tgl;
        logic             req_we;
        logic [7:0]       req_ptr;
        logic [15:0]      req_wdata;
        logic             sda_out;
        logic             oe_n;
    } cic_link_state_type;

    localparam cic_link_state_type CIC_LINK_RST = '{
        rst_sh: 3'h7, scl_sh: 3'h7, sda_sh: 3'h7, ack_sh: 3'h0,
        scl_f: 1'b1, sda_f: 1'b1, ack_f: 1'b0,
        state: CIC_ST_IDLE, kind: CIC_ACK_ADDR, bitcnt: CIC_BIT_RST,
        shreg: 8'h00, rw: 1'b0, lo_next: 1'b0, mack: 1'b0,
        ptr: CIC_PTR_RST, hi_byte: 8'h00, rd_word: CIC_WORD_RST,
        pend_wr: 1'b0, pend_rd: 1'b0, wr_ptr: CIC_PTR_RST,
        wr_data: CIC_WORD_RST, req_tgl: 1'b0, req_we: 1'b0,
        req_ptr: CIC_PTR_RST, req_wdata: CIC_WORD_RST,
        sda_out: 1'b0, oe_n: 1'b1
    };

    typedef struct packed {
        logic [2:0]  req_sh;
        logic        req_f;
        logic [2:0]  mute_sh;
        logic        mute_f;
        logic        ack_tgl;
        logic [15:0] rdata;
        logic        wr_stb;
        logic [7:0]  wr_addr;
        logic [15:0] wr_data;
    } cic_store_state_type;

    localparam cic_store_state_type CIC_STORE_RST = '{
        req_sh: 3'h0, req_f: 1'b0, mute_sh: 3'h0, mute_f: 1'b0,
        ack_tgl: 1'b0, rdata: CIC_WORD_RST, wr_stb: 1'b0,
        wr_addr: CIC_PTR_RST, wr_data: CIC_WORD_RST
    };

endpackage

// *** include/cic_xfer_if.sv ***
`timescale 1ns/1ps
// register request from the link domain and its answer from the store
interface cic_xfer_if;
    logic        req_tgl;
    logic        req_we;
    logic [7:0]  req_ptr;
    logic [15:0] req_wdata;
    logic        ack_tgl;
    logic [15:0] rdata;

    modport link (
        output req_tgl,
        output req_we,
        output req_ptr,
        output req_wdata,
        input  ack_tgl,
        input  rdata
    );

    modport store (
        input  req_tgl,
        input  req_we,
        input  req_ptr,
        input  req_wdata,
        output ack_tgl,
        output rdata
    );
endinterface

// *** core/cic_reg_store.sv ***
`timescale 1ns/1ps
// register array on the reference clock, served by toggle handshake
module cic_reg_store (
    input  wire logic   ref_clk_i,
    input  wire logic   rst_i,
    input  wire logic   control_mode_pin_i,
    cic_xfer_if.store   xfer,
    output logic        quick_mute_o,
    output logic        reg_wr_o,
    output logic [7:0]  reg_addr_o,
    output logic [15:0] reg_data_o
);
    cic_pkg::cic_store_state_type r;
    cic_pkg::cic_store_state_type n;
    logic                         req_new;
    logic                         take;
    logic [15:0]                  mem [0:cic_pkg::CIC_REG_COUNT-1];

    // request toggle accepted once second and third stage agree
    assign req_new = (r.req_sh[1] == r.req_sh[2]) ? r.req_sh[2] : r.req_f;
    assign take    = req_new != r.req_f;

    // next state: synchronisers, write strobe, read answer
    always_comb begin
        n         = r;
        n.req_sh  = {r.req_sh[1:0], xfer.req_tgl};
        n.mute_sh = {r.mute_sh[1:0], control_mode_pin_i};
        n.req_f   = req_new;
        n.wr_stb  = 1'b0;
        if (r.mute_sh[1] == r.mute_sh[2]) begin
            n.mute_f = r.mute_sh[2];
        end
        if (take) begin
            n.ack_tgl = ~r.ack_tgl;
            if (xfer.req_we) begin
                n.wr_stb  = 1'b1;
                n.wr_addr = xfer.req_ptr;
                n.wr_data = xfer.req_wdata;
            end else begin
                n.rdata = mem[xfer.req_ptr];
            end
        end
        if (rst_i) begin
            n = cic_pkg::CIC_STORE_RST;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        r <= n;
    end

    // storage itself has no reset
    always_ff @(posedge ref_clk_i) begin
        if (take && xfer.req_we && !rst_i) begin
            mem[xfer.req_ptr] <= xfer.req_wdata;
        end
    end

    assign xfer.ack_tgl = r.ack_tgl;
    assign xfer.rdata   = r.rdata;
    assign quick_mute_o = r.mute_f;
    assign reg_wr_o     = r.wr_stb;
    assign reg_addr_o   = r.wr_addr;
    assign reg_data_o   = r.wr_data;
endmodule

// *** dv/cic_i2c_slave_properties.sv ***
`timescale 1ns/1ps
// pin and write-port checks for the control slave
module cic_i2c_slave_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        link_clk_i,
    input wire logic        control_clock_pin_i,
    input wire logic        control_data_pin_i,
    input wire logic        control_data_pin_o,
    input wire logic        control_data_oe_n_o,
    input wire logic        control_mode_pin_i,
    input wire logic        quick_mute_o,
    input wire logic        reg_wr_o,
    input wire logic [7:0]  reg_addr_o,
    input wire logic [15:0] reg_data_o
);
    logic       scl_r;
    logic [4:0] fall_cnt_r;
    // link cycles since the bus clock last fell, saturating
    always_ff @(posedge link_clk_i) begin
        scl_r <= control_clock_pin_i;
        if (rst_i)
            fall_cnt_r <= 5'h1F;
        else if (scl_r && !control_clock_pin_i)
            fall_cnt_r <= 5'h00;
        else if (fall_cnt_r != 5'h1F)
            fall_cnt_r <= fall_cnt_r + 5'h01;
    end
    chk_drive_low: assert property (@(posedge link_clk_i)
        disable iff (rst_i) control_data_pin_o == 1'h0)
        else $error("data pin driven high");
    chk_sda_steady: assert property (@(posedge link_clk_i)
        disable iff (rst_i) control_clock_pin_i && $past(control_clock_pin_i)
        |-> $stable(control_data_oe_n_o)) else $error("enable moved");
    chk_edge_timing: assert property (@(posedge link_clk_i)
        disable iff (rst_i) $changed(control_data_oe_n_o)
        |-> fall_cnt_r <= 5'h08) else $error("enable moved late");
    chk_stop_quiet: assert property (@(posedge link_clk_i)
        disable iff (rst_i) $rose(control_data_pin_i) && control_clock_pin_i
        && $past(control_clock_pin_i) |-> control_data_oe_n_o [*8])
        else $error("data pulled after stop");
    chk_wr_pulse: assert property (@(posedge ref_clk_i)
        disable iff (rst_i) reg_wr_o |=> !reg_wr_o)
        else $error("write strobe too long");
    chk_wr_fields: assert property (@(posedge ref_clk_i)
        disable iff (rst_i) $changed(reg_addr_o) || $changed(reg_data_o)
        |-> reg_wr_o) else $error("fields moved without strobe");
    chk_mute_on: assert property (@(posedge ref_clk_i)
        disable iff (rst_i) $rose(control_mode_pin_i) |-> ##[1:12] quick_mute_o)
        else $error("mute not raised");
    chk_mute_off: assert property (@(posedge ref_clk_i)
        disable iff (rst_i) $fell(control_mode_pin_i) |-> ##[1:12] !quick_mute_o)
        else $error("mute not dropped");
    cov_write: cover property (@(posedge ref_clk_i) reg_wr_o);
    cov_ack: cover property (@(posedge link_clk_i) $fell(control_data_oe_n_o));
    cov_mute: cover property (@(posedge ref_clk_i) $rose(quick_mute_o));
endmodule

bind cic_i2c_slave cic_i2c_slave_checker cic_i2c_slave_checker_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .control_clock_pin_i(control_clock_pin_i),
    .control_data_pin_i(control_data_pin_i),
    .control_data_pin_o(control_data_pin_o),
    .control_data_oe_n_o(control_data_oe_n_o),
    .control_mode_pin_i(control_mode_pin_i), .quick_mute_o(quick_mute_o),
    .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_data_o(reg_data_o));

// *** dv/cic_host_model.sv ***
`timescale 1ns/1ps
// two-wire bus master: drives the clock, pulls data low only
module cic_host_model (
    input  wire logic link_clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // quarter bit in link cycles, about 390 kHz bit rate
    localparam int QTR = 4;
    // idle bus: both lines released
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic tick();
        repeat (QTR) @(posedge link_clk_i);
        #1;
    endtask
    // data first, clock a quarter bit later
    task automatic step(input logic s, input logic c);
        tick();
        sda_o = s;
        tick();
        scl_o = c;
    endtask
    task automatic bit_io(input logic b, output logic r);
        step(b, 1'h1);
        tick();
        r = sda_i;
        tick();
        scl_o = 1'h0;
    endtask
    // start from idle, or repeated start with the clock low
    task automatic start();
        if (!scl_o)
            step(1'h1, 1'h1);
        step(1'h0, 1'h0);
    endtask
    task automatic stop();
        step(1'h0, 1'h1);
        step(1'h1, 1'h1);
    endtask
    // write a byte, data released for the acknowledge slot
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'h1, r);
        ack = !r;
    endtask
    // read a byte, then acknowledge it or not
    task automatic rbyte(input logic give, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'h1, d[i]);
        bit_io(!give, r);
    endtask
endmodule

// *** dv/cic_i2c_slave_tb_top.sv ***
`timescale 1ns/1ps
// bench for the control slave, bus driven by the master model
module cic_i2c_slave_tb_top;
    logic        ref_clk_i;
    logic        rst_i;
    logic        link_clk_i;
    logic        scl;
    logic        host_sda;
    logic        sda;
    logic        pin_o;
    logic        oe_n;
    logic        mode;
    logic        mute;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] data;
    logic [23:0] wr_q[$];
    int          error_cnt;
    int          check_count;

    // wired-and data line with pull-up
    assign sda = host_sda & (oe_n | pin_o);

    cic_i2c_slave cic_i2c_slave_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
        .control_clock_pin_i(scl), .control_data_pin_i(sda),
        .control_data_pin_o(pin_o), .control_data_oe_n_o(oe_n),
        .control_mode_pin_i(mode), .quick_mute_o(mute),
        .reg_wr_o(wr), .reg_addr_o(addr), .reg_data_o(data));
    cic_host_model cic_host_model_i (
        .link_clk_i(link_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));

    initial begin
        ref_clk_i = 1'h0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        link_clk_i = 1'h0;
        #13;
        forever #80 link_clk_i = ~link_clk_i;
    end
    // log every register write as address and data
    always @(posedge ref_clk_i)
        if (wr === 1'h1)
            wr_q.push_back({addr, data});

    task automatic check(input string what, input logic [23:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wb(input logic [7:0] d, input logic ack);
        logic a;
        cic_host_model_i.wbyte(d, a);
        check("ack", 24'(a), 24'(ack));
    endtask
    task automatic wait_wr(input int n);
        int k;
        k = 0;
        while (wr_q.size() < n && k < 400) begin
            @(posedge ref_clk_i);
            k++;
        end
        check("writes", 24'(wr_q.size()), 24'(n));
        if (k == 400)
            print_verdict();
    endtask
    task automatic test_mute();
        int k;
        for (int v = 1; v >= 0; v--) begin
            @(posedge ref_clk_i);
            #1;
            mode = 1'(v);
            k = 0;
            while (mute !== 1'(v) && k < 50) begin
                @(posedge ref_clk_i);
                k++;
            end
            check("mute", 24'(mute), 24'(v));
            if (k == 50)
                print_verdict();
        end
    endtask
    task automatic test_write();
        logic [7:0] b [6] = '{8'h30, 8'h10, 8'hAB, 8'hCD, 8'h12, 8'h34};
        wr_q.delete();
        cic_host_model_i.start();
        foreach (b[i])
            wb(b[i], 1'h1);
        cic_host_model_i.stop();
        wait_wr(2);
        check("wr", wr_q.pop_front(), 24'h10ABCD);
        check("wr", wr_q.pop_front(), 24'h111234);
    endtask
    // pointer wrap, then a restart that drops an odd byte
    task automatic test_wrap();
        logic [7:0] b [7] = '{8'h30, 8'hFF, 8'h5A, 8'h5A, 8'h0F, 8'h0F, 8'h77};
        logic [7:0] c [4] = '{8'h30, 8'h21, 8'h22, 8'h33};
        wr_q.delete();
        cic_host_model_i.start();
        foreach (b[i])
            wb(b[i], 1'h1);
        cic_host_model_i.start();
        foreach (c[i])
            wb(c[i], 1'h1);
        cic_host_model_i.stop();
        wait_wr(3);
        check("wr", wr_q.pop_front(), 24'hFF5A5A);
        check("wr", wr_q.pop_front(), 24'h000F0F);
        check("wr", wr_q.pop_front(), 24'h212233);
    endtask
    task automatic test_read();
        logic [7:0] e [4] = '{8'hAB, 8'hCD, 8'h12, 8'h34};
        logic [7:0] d;
        cic_host_model_i.start();
        wb(8'h30, 1'h1);
        wb(8'h10, 1'h1);
        cic_host_model_i.start();
        wb(8'h31, 1'h1);
        foreach (e[i]) begin
            cic_host_model_i.rbyte(i < 3, d);
            check("read", 24'(d), 24'(e[i]));
        end
        repeat (6) @(posedge link_clk_i);
        check("release", 24'(sda), 24'h1);
        cic_host_model_i.stop();
    endtask
    task automatic test_foreign();
        logic [7:0] b [2] = '{8'h32, 8'hB0};
        wr_q.delete();
        foreach (b[i]) begin
            cic_host_model_i.start();
            wb(b[i], 1'h0);
            wb(8'h10, 1'h0);
            cic_host_model_i.stop();
        end
        wait_wr(0);
    endtask

    initial begin
        error_cnt = 0;
        check_count = 0;
        rst_i = 1'h1;
        mode = 1'h0;
        repeat (10) @(posedge link_clk_i);
        @(posedge ref_clk_i);
        #1;
        rst_i = 1'h0;
        check("reset", {oe_n, wr, mute, 5'h00, data}, 24'h800000);
        check("reset addr", 24'(addr), 24'h000000);
        repeat (8) @(posedge link_clk_i);
        test_mute();
        test_write();
        test_wrap();
        test_read();
        test_foreign();
        print_verdict();
    end
    initial begin
        repeat (100000) @(posedge ref_clk_i);
        error_cnt++;
        print_verdict();
    end
endmodule
